/* File: xbadc_cfg.svh */
// Register offsets, field positions, reset values and decode constants
`ifndef XBADC_CFG_SVH
`define XBADC_CFG_SVH
`define XB_OFF_ACT      8'h30
`define XB_OFF_BASE_H   8'h60
`define XB_OFF_BASE_L   8'h61
`define XB_OFF_IRQ_NUM  8'h70
`define XB_OFF_IRQ_KND  8'h71
`define XB_OFF_DMA_A    8'h74
`define XB_OFF_DMA_B    8'h75
`define XB_OFF_IO_CFG   8'hf0
`define XB_OFF_IO_BH    8'hf1
`define XB_OFF_IO_BL    8'hf2
`define XB_OFF_IO_SZ    8'hf3
`define XB_OFF_MEM_CFG  8'hf4
`define XB_OFF_MEM_BH   8'hf5
`define XB_OFF_MEM_BL   8'hf6
`define XB_OFF_MEM_SZ   8'hf7
`define XB_OFF_IRQ_AB   8'hf8
`define XB_OFF_IRQ_CD   8'hf9
`define XB_RST_ZERO     8'h00
`define XB_RST_DMA      8'h04
`define XB_ACT_BIT      0
`define XB_BASEL_RO     4'h0
`define XB_IO_UIO_BIT   7
`define XB_IO_DBG_BIT   6
`define XB_IO_RTC_LSB   4
`define XB_IO_PWR_LSB   2
`define XB_IO_KBD_LSB   0
`define XB_MEM_ID_LSB   4
`define XB_MEM_HUB_BIT  3
`define XB_MEM_UMEM_BIT 2
`define XB_MEM_EXT_BIT  1
`define XB_MEM_LPC_BIT  0
`define XB_IO_SZ_MIN    4'h1
`define XB_IO_SZ_MAX    4'h8
`define XB_MEM_SZ_MAX   4'hc
`define XB_IO_DBG_ADDR  16'h0080
`define XB_IO_KBD_ADDR  16'h0060
`define XB_IO_PWR_ADDR  16'h0062
`define XB_IO_RTC_ADDR  16'h0070
`define XB_IO_ALT_OFS   16'h0300
`define XB_IO_PAIR_OFS  16'h0004
`define XB_BIOS_F_SEG   16'h000f
`define XB_BIOS_E_SEG   16'h000e
`define XB_BIOS_TOP     10'h3ff
`define XB_EXT_AW       28
`endif

/* File: xbadc_ext_model.sv */
// Extension-bus device model answering forwarded reads
`timescale 1ns/1ps
`default_nettype none
module xbadc_ext_model
   import xbadc_pkg::*;
(
   input  wire logic                  i_clock,
   input  wire xbadc_pkg::xbadc_ext_t i_ext,
   output var  logic [7:0]            o_rdata
);
   logic [7:0] churn_q = 8'h00;
   // Off-cycle data keeps moving so a late or early sample never matches
   always_ff @(posedge i_clock)
   begin
      churn_q <= churn_q + 8'h3b;
   end
   // Read data follows the address, so the bench can predict it
   always_comb
   begin
      o_rdata = i_ext.rd ? (i_ext.addr[7:0] ^ 8'h5a) : ~churn_q;
   end
endmodule
`default_nettype wire

/* File: xbadc_io_dec.sv */
// I/O zone decoder for forwarded host I/O cycles
`timescale 1ns/1ps
`default_nettype none
`include "xbadc_cfg.svh"
module xbadc_io_dec
   import xbadc_pkg::*;
(
   input  wire xbadc_pkg::xbadc_host_t   i_host,
   input  wire logic [7:0]               i_io_cfg,
   input  wire logic [15:0]              i_io_base,
   input  wire logic [3:0]               i_io_size,
   output var  xbadc_pkg::xbadc_io_hit_t o_hit
);
   function automatic logic pair_hit(input logic [15:0] a, input logic [15:0] b);
      pair_hit = (a == b) || (a == b + `XB_IO_PAIR_OFS);
   endfunction

   logic        is_io;
   logic [15:0] a;
   logic [15:0] mask;
   logic [1:0]  kf;
   logic [1:0]  pf;
   logic [1:0]  rf;

   always_comb
   begin
      is_io = i_host.valid && (i_host.kind == XB_IO);
      a     = i_host.addr[15:0];
      kf    = i_io_cfg[`XB_IO_KBD_LSB +: 2];
      pf    = i_io_cfg[`XB_IO_PWR_LSB +: 2];
      rf    = i_io_cfg[`XB_IO_RTC_LSB +: 2];
      mask  = 16'hffff << i_io_size;
      o_hit = '0;
      // Reserved code 2'b11 decodes nothing in the keyboard and power fields; in the RTC field it decodes 0x70-0x73
      o_hit.keyboard_ctl_zone = is_io && ((kf == 2'b01 && pair_hit(a, `XB_IO_KBD_ADDR)) ||
         (kf == 2'b10 && pair_hit(a, `XB_IO_KBD_ADDR + `XB_IO_ALT_OFS)));
      o_hit.power_mgmt_zone = is_io && ((pf == 2'b01 && pair_hit(a, `XB_IO_PWR_ADDR)) ||
         (pf == 2'b10 && pair_hit(a, `XB_IO_PWR_ADDR + `XB_IO_ALT_OFS)));
      o_hit.rtc_zone = is_io && ((rf == 2'b01 && {a[15:1], 1'b0} == `XB_IO_RTC_ADDR) ||
         (rf == 2'b10 && {a[15:1], 1'b0} == `XB_IO_RTC_ADDR + `XB_IO_ALT_OFS) ||
         (rf == 2'b11 && {a[15:2], 2'b00} == `XB_IO_RTC_ADDR));
      o_hit.debug_port_zone = is_io && i_io_cfg[`XB_IO_DBG_BIT] &&
         (a == `XB_IO_DBG_ADDR);
      // Sizes outside 2..256 bytes never match
      o_hit.user_io_window = is_io && i_io_cfg[`XB_IO_UIO_BIT] &&
         (i_io_size >= `XB_IO_SZ_MIN) && (i_io_size <= `XB_IO_SZ_MAX) &&
         (((a ^ i_io_base) & mask) == 16'h0000);
   end
endmodule
`default_nettype wire

/* File: xbadc_mem_dec.sv */
// Memory and firmware-hub range decoder
`timescale 1ns/1ps
`default_nettype none
`include "xbadc_cfg.svh"
module xbadc_mem_dec
   import xbadc_pkg::*;
(
   input  wire xbadc_pkg::xbadc_host_t    i_host,
   input  wire logic [7:0]                i_mem_cfg,
   input  wire logic [31:0]               i_mem_base,
   input  wire logic [3:0]                i_mem_size,
   output var  xbadc_pkg::xbadc_mem_hit_t o_hit
);
   logic        is_mem;
   logic        is_hub;
   logic        top;
   logic [31:0] mask;

   always_comb
   begin
      is_mem = i_host.valid && (i_host.kind == XB_MEM);
      is_hub = i_host.valid && (i_host.kind == XB_HUB);
      top    = i_host.addr[31:22] == `XB_BIOS_TOP;
      // Window granule is 64 Kbyte since the base carries no low 16 bits
      mask   = 32'hffff_0000 << i_mem_size;
      o_hit  = '0;
      o_hit.user_memory_window = is_mem && i_mem_cfg[`XB_MEM_UMEM_BIT] &&
         (i_mem_size <= `XB_MEM_SZ_MAX) &&
         (((i_host.addr ^ i_mem_base) & mask) == 32'h0000_0000);
      o_hit.bios = (is_mem && i_mem_cfg[`XB_MEM_LPC_BIT] &&
         (top || i_host.addr[31:16] == `XB_BIOS_F_SEG ||
         (i_mem_cfg[`XB_MEM_EXT_BIT] && i_host.addr[31:16] == `XB_BIOS_E_SEG))) ||
         (is_hub && i_mem_cfg[`XB_MEM_HUB_BIT] && top &&
         i_host.hub_id == i_mem_cfg[`XB_MEM_ID_LSB +: 4]);
   end
endmodule
`default_nettype wire

/* File: xbadc_pkg.sv */
// Types shared by the extension-bus decode blocks
package xbadc_pkg;
   typedef enum logic [1:0] {XB_IO, XB_MEM, XB_HUB} xbadc_kind_t;
   typedef struct packed {
      logic        valid;
      xbadc_kind_t kind;
      logic        write;
      logic [3:0]  hub_id;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } xbadc_host_t;
   typedef struct packed {
      logic user_io_window;
      logic debug_port_zone;
      logic rtc_zone;
      logic power_mgmt_zone;
      logic keyboard_ctl_zone;
   } xbadc_io_hit_t;
   typedef struct packed {
      logic user_memory_window;
      logic bios;
   } xbadc_mem_hit_t;
   typedef struct packed {
      xbadc_io_hit_t  io;
      xbadc_mem_hit_t mem;
   } xbadc_sel_t;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [27:0] addr;
      logic [7:0]  data;
   } xbadc_ext_t;
   typedef enum logic [1:0] {XB_BOOT_LOAD, XB_BOOT_ARMED, XB_BOOT_DONE} xbadc_boot_t;
endpackage

/* File: xbadc_top.sv */
// Extension-bus address decode configuration and forwarding
`timescale 1ns/1ps
`default_nettype none
`include "xbadc_cfg.svh"
module xbadc_top
(
   input  wire logic                  i_clock,
   input  wire logic                  i_rst_n,
   input  wire logic [7:0]            i_reg_addr,
   input  wire logic [7:0]            i_reg_wdata,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   output var  logic [7:0]            o_reg_rdata,
   input  wire logic [2:0]            i_boot_strap_select,
   input  wire xbadc_pkg::xbadc_host_t i_host,
   output var  logic                  o_claim,
   output var  logic                  o_host_done,
   output var  logic [7:0]            o_host_rdata,
   input  wire logic [2:0]            i_legacy_cs_mapped,
   output var  xbadc_pkg::xbadc_sel_t o_sel,
   output var  xbadc_pkg::xbadc_ext_t o_ext,
   input  wire logic [7:0]            i_ext_rdata
);
   import xbadc_pkg::*;

   logic [7:0]     act_q;
   logic [7:0]     base_h_q;
   logic [7:0]     base_l_q;
   logic [7:0]     io_cfg_q;
   logic [7:0]     io_bh_q;
   logic [7:0]     io_bl_q;
   logic [3:0]     io_sz_q;
   logic [7:0]     mem_cfg_q;
   logic [7:0]     mem_cfg_d;
   logic [7:0]     mem_bh_q;
   logic [7:0]     mem_bl_q;
   logic [7:0]     mem_sz_q;
   logic [7:0]     irq_ab_q;
   logic [7:0]     irq_cd_q;
   logic [2:0]     strap_s1_q;
   logic [2:0]     strap_s2_q;
   xbadc_boot_t    boot_q;
   xbadc_boot_t    boot_d;
   xbadc_io_hit_t  io_hit;
   xbadc_mem_hit_t mem_hit;
   logic           wr_ok;
   logic           bios_rd;
   logic           legacy_blocked;
   logic           pend_q;
   logic           pend_rd_q;

   // Strap pins come from outside the clock domain
   always_ff @(posedge i_clock)
   begin
      strap_s1_q <= i_boot_strap_select;
      strap_s2_q <= strap_s1_q;
   end

   // Only the activate register stays writable while inactive
   assign wr_ok = i_reg_wr && (i_reg_addr == `XB_OFF_ACT || act_q[`XB_ACT_BIT]);

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         act_q    <= `XB_RST_ZERO;
         base_h_q <= `XB_RST_ZERO;
         base_l_q <= `XB_RST_ZERO;
         irq_ab_q <= `XB_RST_ZERO;
         irq_cd_q <= `XB_RST_ZERO;
      end
      else if (wr_ok)
      begin
         case (i_reg_addr)
            `XB_OFF_ACT:    act_q    <= i_reg_wdata;
            `XB_OFF_BASE_H: base_h_q <= i_reg_wdata;
            `XB_OFF_BASE_L: base_l_q <= {i_reg_wdata[7:4], `XB_BASEL_RO};
            `XB_OFF_IRQ_AB: irq_ab_q <= i_reg_wdata;
            `XB_OFF_IRQ_CD: irq_cd_q <= i_reg_wdata;
            default:        ;
         endcase
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         io_cfg_q <= `XB_RST_ZERO;
         io_bh_q  <= `XB_RST_ZERO;
         io_bl_q  <= `XB_RST_ZERO;
         io_sz_q  <= 4'h0;
      end
      else if (wr_ok)
      begin
         case (i_reg_addr)
            `XB_OFF_IO_CFG: io_cfg_q <= i_reg_wdata;
            `XB_OFF_IO_BH:  io_bh_q  <= i_reg_wdata;
            `XB_OFF_IO_BL:  io_bl_q  <= i_reg_wdata;
            `XB_OFF_IO_SZ:  io_sz_q  <= i_reg_wdata[3:0];
            default:        ;
         endcase
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         mem_bh_q <= `XB_RST_ZERO;
         mem_bl_q <= `XB_RST_ZERO;
         mem_sz_q <= `XB_RST_ZERO;
      end
      else if (wr_ok)
      begin
         case (i_reg_addr)
            `XB_OFF_MEM_BH: mem_bh_q <= i_reg_wdata;
            `XB_OFF_MEM_BL: mem_bl_q <= i_reg_wdata;
            `XB_OFF_MEM_SZ: mem_sz_q <= i_reg_wdata;
            default:        ;
         endcase
      end
   end

   xbadc_io_dec u_io_dec
   (
      .i_host    (i_host),
      .i_io_cfg  (io_cfg_q),
      .i_io_base ({io_bh_q, io_bl_q}),
      .i_io_size (io_sz_q),
      .o_hit     (io_hit)
   );

   xbadc_mem_dec u_mem_dec
   (
      .i_host     (i_host),
      .i_mem_cfg  (mem_cfg_q),
      .i_mem_base ({mem_bh_q, mem_bl_q, 16'h0000}),
      .i_mem_size (mem_sz_q[3:0]),
      .o_hit      (mem_hit)
   );

   assign o_claim = (|io_hit) || (|mem_hit);
   assign bios_rd = o_claim && mem_hit.bios && !i_host.write;

   // Boot detection; a software write to the memory config wins over auto clear
   always_comb
   begin
      boot_d    = boot_q;
      mem_cfg_d = mem_cfg_q;
      case (boot_q)
         XB_BOOT_LOAD:
         begin
            if (strap_s2_q != 3'b000)
            begin
               mem_cfg_d[`XB_MEM_LPC_BIT] = 1'b1;
               mem_cfg_d[`XB_MEM_HUB_BIT] = 1'b1;
               boot_d = XB_BOOT_ARMED;
            end
            else
            begin
               boot_d = XB_BOOT_DONE;
            end
         end
         XB_BOOT_ARMED:
         begin
            if (bios_rd)
            begin
               if (i_host.kind == XB_MEM)
               begin
                  mem_cfg_d[`XB_MEM_HUB_BIT] = 1'b0;
               end
               else
               begin
                  mem_cfg_d[`XB_MEM_LPC_BIT] = 1'b0;
               end
               boot_d = XB_BOOT_DONE;
            end
         end
         XB_BOOT_DONE:
         begin
            boot_d = XB_BOOT_DONE;
         end
         default:
         begin
            boot_d = XB_BOOT_DONE;
         end
      endcase
      if (wr_ok && i_reg_addr == `XB_OFF_MEM_CFG)
      begin
         mem_cfg_d = i_reg_wdata;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         boot_q    <= XB_BOOT_LOAD;
         mem_cfg_q <= `XB_RST_ZERO;
      end
      else
      begin
         boot_q    <= boot_d;
         mem_cfg_q <= mem_cfg_d;
      end
   end

   // Register read data stand only in the cycle after the strobe
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || !i_reg_rd)
      begin
         o_reg_rdata <= `XB_RST_ZERO;
      end
      else if (i_reg_addr != `XB_OFF_ACT && !act_q[`XB_ACT_BIT])
      begin
         o_reg_rdata <= `XB_RST_ZERO;
      end
      else
      begin
         case (i_reg_addr)
            `XB_OFF_ACT:     o_reg_rdata <= act_q;
            `XB_OFF_BASE_H:  o_reg_rdata <= base_h_q;
            `XB_OFF_BASE_L:  o_reg_rdata <= {base_l_q[7:4], `XB_BASEL_RO};
            `XB_OFF_IRQ_NUM: o_reg_rdata <= `XB_RST_ZERO;
            `XB_OFF_IRQ_KND: o_reg_rdata <= `XB_RST_ZERO;
            `XB_OFF_DMA_A:   o_reg_rdata <= `XB_RST_DMA;
            `XB_OFF_DMA_B:   o_reg_rdata <= `XB_RST_DMA;
            `XB_OFF_IO_CFG:  o_reg_rdata <= io_cfg_q;
            `XB_OFF_IO_BH:   o_reg_rdata <= io_bh_q;
            `XB_OFF_IO_BL:   o_reg_rdata <= io_bl_q;
            `XB_OFF_IO_SZ:   o_reg_rdata <= {4'h0, io_sz_q};
            `XB_OFF_MEM_CFG: o_reg_rdata <= mem_cfg_q;
            `XB_OFF_MEM_BH:  o_reg_rdata <= mem_bh_q;
            `XB_OFF_MEM_BL:  o_reg_rdata <= mem_bl_q;
            `XB_OFF_MEM_SZ:  o_reg_rdata <= mem_sz_q;
            `XB_OFF_IRQ_AB:  o_reg_rdata <= irq_ab_q;
            `XB_OFF_IRQ_CD:  o_reg_rdata <= irq_cd_q;
            default:         o_reg_rdata <= `XB_RST_ZERO;
         endcase
      end
   end

   // Legacy zones with no chip select still claim, but never reach the pins
   assign legacy_blocked = (io_hit.keyboard_ctl_zone && !i_legacy_cs_mapped[0]) ||
                           (io_hit.power_mgmt_zone && !i_legacy_cs_mapped[1]) ||
                           (io_hit.rtc_zone && !i_legacy_cs_mapped[2]);

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || !(i_host.valid && o_claim))
      begin
         o_ext     <= '0;
         o_sel     <= '0;
         pend_q    <= 1'b0;
         pend_rd_q <= 1'b0;
      end
      else
      begin
         o_sel.io   <= io_hit;
         o_sel.mem  <= mem_hit;
         o_ext.addr <= i_host.addr[`XB_EXT_AW-1:0];
         o_ext.data <= i_host.wdata;
         o_ext.rd   <= !i_host.write && !legacy_blocked;
         o_ext.wr   <= i_host.write && !legacy_blocked;
         pend_q     <= 1'b1;
         pend_rd_q  <= !i_host.write && !legacy_blocked;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         o_host_done  <= 1'b0;
         o_host_rdata <= `XB_RST_ZERO;
      end
      else
      begin
         o_host_done  <= pend_q;
         o_host_rdata <= pend_rd_q ? i_ext_rdata : `XB_RST_ZERO;
      end
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   act_read_a: assert property (
      (i_reg_rd && !act_q[`XB_ACT_BIT] && i_reg_addr != `XB_OFF_ACT) |=> o_reg_rdata == 8'h00)
      else $error("Read of inactive unit not zero");
   act_write_a: assert property (
      (i_reg_wr && !act_q[`XB_ACT_BIT] && i_reg_addr == `XB_OFF_IO_CFG) |=> $stable(io_cfg_q))
      else $error("Write to inactive unit took effect");
   base_low_a: assert property (
      (i_reg_rd && i_reg_addr == `XB_OFF_BASE_L) |=> o_reg_rdata[3:0] == 4'h0)
      else $error("Base low nibble not zero");
   irq_zero_a: assert property (
      (i_reg_rd && (i_reg_addr == `XB_OFF_IRQ_NUM || i_reg_addr == `XB_OFF_IRQ_KND))
      |=> o_reg_rdata == 8'h00)
      else $error("Interrupt register not zero");
   unmapped_zone_a: assert property (
      (i_host.valid && legacy_blocked && !i_host.write)
      |=> (!o_ext.rd && !o_ext.wr) ##1 (o_host_done && o_host_rdata == 8'h00))
      else $error("Unmapped zone reached extension bus");
   debug_port_a: assert property (
      (i_host.valid && i_host.kind == XB_IO && i_host.addr[15:0] == `XB_IO_DBG_ADDR &&
      io_cfg_q[`XB_IO_DBG_BIT]) |-> o_claim ##1 o_sel.io.debug_port_zone)
      else $error("Debug port cycle not forwarded");
   bios_seg_a: assert property (
      (i_host.valid && i_host.kind == XB_MEM && mem_cfg_q[`XB_MEM_LPC_BIT] &&
      i_host.addr[31:16] == `XB_BIOS_F_SEG) |-> o_claim)
      else $error("BIOS segment not claimed");
   strap_set_a: assert property (
      (boot_q == XB_BOOT_LOAD && strap_s2_q != 3'b000 && !i_reg_wr)
      |=> (mem_cfg_q[`XB_MEM_LPC_BIT] && mem_cfg_q[`XB_MEM_HUB_BIT]))
      else $error("Strap did not enable BIOS");
   auto_clear_a: assert property (
      (boot_q == XB_BOOT_ARMED && bios_rd && i_host.kind == XB_MEM && !i_reg_wr)
      |=> (!mem_cfg_q[`XB_MEM_HUB_BIT] && mem_cfg_q[`XB_MEM_LPC_BIT] && boot_q == XB_BOOT_DONE))
      else $error("First BIOS read did not clear hub enable");
   once_only_a: assert property (
      (boot_q == XB_BOOT_DONE && !(i_reg_wr && i_reg_addr == `XB_OFF_MEM_CFG))
      |=> $stable(mem_cfg_q))
      else $error("BIOS enable changed after detection");
   ext_addr_a: assert property (
      (o_ext.rd || o_ext.wr) |-> o_ext.addr == $past(i_host.addr[`XB_EXT_AW-1:0]))
      else $error("Extension address mismatch");
   read_back_a: assert property (
      o_ext.rd |=> (o_host_done && o_host_rdata == $past(i_ext_rdata)))
      else $error("Extension read data not returned");
   io_reset_a: assert property (
      $rose(i_rst_n) |-> io_cfg_q == 8'h00)
      else $error("I/O config not zero after reset");
   no_claim_a: assert property (
      (i_host.valid && !o_claim) |=> (o_sel == '0 && !o_ext.rd && !o_ext.wr))
      else $error("Unclaimed cycle selected");
endmodule
`default_nettype wire

/* File: xbus_address_decode_config_tb.sv */
// Self-checking bench for the extension-bus decode configuration block
`timescale 1ns/1ps
`default_nettype none
module xbus_address_decode_config_tb;
   import xbadc_pkg::*;
   logic              clk = 1'b0;
   logic              i_rst_n = 1'b0;
   logic [7:0]        i_reg_addr = 8'h00;
   logic [7:0]        i_reg_wdata = 8'h00;
   logic              i_reg_wr = 1'b0;
   logic              i_reg_rd = 1'b0;
   logic [2:0]        i_boot_strap_select = 3'h1;
   xbadc_host_t       i_host = '0;
   logic [2:0]        i_legacy_cs_mapped = 3'h7;
   logic [7:0]        o_reg_rdata;
   logic              o_claim;
   logic              o_host_done;
   logic [7:0]        o_host_rdata;
   xbadc_sel_t        o_sel;
   xbadc_ext_t        o_ext;
   logic [7:0]        ext_rdata;
   integer            errors = 0;
   integer            check_count = 0;
   integer            seed = 2;
   logic [31:0]       r;
   logic [15:0]       a;
   logic [7:0]        cfg;
   logic [2:0]        cs;
   logic [3:0]        sz;
   logic [4:0]        e;
   logic              f;
   logic [15:0]       hot [16] = '{16'h0060, 16'h0064, 16'h0360, 16'h0364, 16'h0062,
      16'h0066, 16'h0362, 16'h0366, 16'h0070, 16'h0071, 16'h0072, 16'h0073, 16'h0370,
      16'h0371, 16'h0080, 16'h0344};
   initial
   begin
      forever #4 clk = ~clk;
   end
   xbadc_top uut (.i_clock(clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .i_boot_strap_select(i_boot_strap_select),
      .i_host(i_host), .o_claim(o_claim), .o_host_done(o_host_done),
      .o_host_rdata(o_host_rdata), .i_legacy_cs_mapped(i_legacy_cs_mapped),
      .o_sel(o_sel), .o_ext(o_ext), .i_ext_rdata(ext_rdata));
   xbadc_ext_model ext (.i_clock(clk), .i_ext(o_ext), .o_rdata(ext_rdata));
   task close_out;
   begin
      $display("Comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
   begin
      check_count++;
      if (g !== x)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   end
   endtask
   task chk_s(input xbadc_sel_t g, input logic [6:0] x);
   begin
      check_count++;
      if (g !== x)
      begin
         errors++;
         $display("Error at %0t: select %h expected %h", $time, g, x);
      end
   end
   endtask
   task wr(input logic [7:0] ad, input logic [7:0] d);
   begin
      i_reg_addr <= ad;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge clk);
      i_reg_wr <= 1'b0;
      @(posedge clk);
   end
   endtask
   task rd(input logic [7:0] ad, input logic [7:0] x);
   begin
      i_reg_addr <= ad;
      i_reg_rd <= 1'b1;
      @(posedge clk);
      i_reg_rd <= 1'b0;
      @(negedge clk);
      chk(o_reg_rdata, x);
      @(posedge clk);
   end
   endtask
   // One host cycle; es is the expected select set, fw whether it reaches the bus
   task host(input xbadc_kind_t k, input logic w, input logic [3:0] id, input logic [31:0] ad,
      input logic [7:0] d, input logic [6:0] es, input logic fw, input logic [7:0] er);
   begin
      i_host <= '{valid: 1'b1, kind: k, write: w, hub_id: id, addr: ad, wdata: d};
      @(negedge clk);
      chk(o_claim, |es);
      @(posedge clk);
      i_host.valid <= 1'b0;
      @(negedge clk);
      chk_s(o_sel, es);
      chk(o_ext.rd, fw && !w);
      chk(o_ext.wr, fw && w);
      if (fw)
         chk(o_ext.addr, ad[27:0]);
      if (fw && w)
         chk(o_ext.data, d);
      @(negedge clk);
      chk(o_host_done, |es);
      if (|es)
         chk(o_host_rdata, er);
      @(posedge clk);
   end
   endtask
   task rst(input logic [2:0] strap);
   begin
      i_rst_n <= 1'b0;
      i_boot_strap_select <= strap;
      repeat (4) @(posedge clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   end
   endtask
   function logic lg(input logic [1:0] fl, input logic [15:0] ad, input logic [15:0] lo);
      lg = (fl == 2'h1 && (ad == lo || ad == lo + 16'h0004))
         || (fl == 2'h2 && (ad == lo + 16'h0300 || ad == lo + 16'h0304));
   endfunction
   function logic [4:0] exio(input logic [7:0] c, input logic [3:0] s, input logic [15:0] b,
      input logic [15:0] ad);
      logic rtc;
      rtc = (c[5:4] == 2'h1 && (ad == 16'h0070 || ad == 16'h0071))
         || (c[5:4] == 2'h2 && (ad == 16'h0370 || ad == 16'h0371))
         || (c[5:4] == 2'h3 && ad >= 16'h0070 && ad <= 16'h0073);
      exio = {c[7] && s >= 4'h1 && s <= 4'h8 && (ad >> s) == (b >> s),
         c[6] && ad == 16'h0080, rtc, lg(c[3:2], ad, 16'h0062), lg(c[1:0], ad, 16'h0060)};
   endfunction
   initial
   begin
      rst(3'h1);
      wr(8'hf0, 8'hff);
      rd(8'hf0, 8'h00);
      wr(8'h30, 8'h01);
      rd(8'hf0, 8'h00);
      wr(8'h61, 8'hff);
      rd(8'h61, 8'hf0);
      wr(8'h70, 8'hff);
      rd(8'h70, 8'h00);
      rd(8'h71, 8'h00);
      rd(8'h74, 8'h04);
      rd(8'h40, 8'h00);
      wr(8'hf9, 8'h3c);
      rd(8'hf9, 8'h3c);
      rd(8'hf4, 8'h09);
      host(XB_MEM, 1'b0, 4'h0, 32'h000f_1234, 8'h00, 7'h01, 1'b1, 8'h6e);
      rd(8'hf4, 8'h01);
      host(XB_HUB, 1'b0, 4'h0, 32'hffc0_0000, 8'h00, 7'h00, 1'b0, 8'h00);
      wr(8'hf4, 8'h09);
      host(XB_HUB, 1'b0, 4'h0, 32'hffc0_0010, 8'h00, 7'h01, 1'b1, 8'h4a);
      rd(8'hf4, 8'h09);
      // Hub cycles must carry the identifier held in the memory config
      wr(8'hf4, 8'h59);
      host(XB_HUB, 1'b0, 4'h3, 32'hffc0_0020, 8'h00, 7'h00, 1'b0, 8'h00);
      host(XB_HUB, 1'b0, 4'h5, 32'hffc0_0020, 8'h00, 7'h01, 1'b1, 8'h7a);
      rd(8'hf4, 8'h59);
      host(XB_MEM, 1'b1, 4'h0, 32'h000e_0000, 8'ha5, 7'h00, 1'b0, 8'h00);
      wr(8'hf4, 8'h0b);
      host(XB_MEM, 1'b1, 4'h0, 32'h000e_0001, 8'ha5, 7'h01, 1'b1, 8'h00);
      host(XB_MEM, 1'b0, 4'h0, 32'hffff_ffff, 8'h00, 7'h01, 1'b1, 8'ha5);
      wr(8'hf5, 8'h12);
      wr(8'hf6, 8'h34);
      wr(8'hf7, 8'h00);
      wr(8'hf4, 8'h04);
      rd(8'hf6, 8'h34);
      host(XB_MEM, 1'b0, 4'h0, 32'h1234_abcd, 8'h00, 7'h02, 1'b1, 8'h97);
      host(XB_MEM, 1'b0, 4'h0, 32'h1235_0000, 8'h00, 7'h00, 1'b0, 8'h00);
      // 128 Kbyte window covers the next 64 Kbyte; an oversize code matches nothing
      wr(8'hf7, 8'h01);
      host(XB_MEM, 1'b0, 4'h0, 32'h1235_0000, 8'h00, 7'h02, 1'b1, 8'h5a);
      wr(8'hf7, 8'hfd);
      rd(8'hf7, 8'hfd);
      host(XB_MEM, 1'b0, 4'h0, 32'h1234_abcd, 8'h00, 7'h00, 1'b0, 8'h00);
      // Largest user I/O window: 256 bytes at 0x0100, then an invalid size code
      wr(8'hf1, 8'h01);
      wr(8'hf2, 8'h00);
      wr(8'hf3, 8'h08);
      wr(8'hf0, 8'h80);
      host(XB_IO, 1'b0, 4'h0, 32'h0000_01ff, 8'h00, 7'h40, 1'b1, 8'ha5);
      host(XB_IO, 1'b0, 4'h0, 32'h0000_0200, 8'h00, 7'h00, 1'b0, 8'h00);
      wr(8'hf3, 8'h09);
      rd(8'hf3, 8'h09);
      host(XB_IO, 1'b0, 4'h0, 32'h0000_0100, 8'h00, 7'h00, 1'b0, 8'h00);
      // Random zone settings, chip-select maps and addresses around the legacy ports
      wr(8'hf1, 8'h03);
      wr(8'hf2, 8'h40);
      repeat (40)
      begin
         r = $random(seed);
         cfg = r[7:0];
         cs = r[10:8];
         sz = {2'b00, r[12:11]} + {3'b000, r[13]};
         i_legacy_cs_mapped <= cs;
         wr(8'hf0, cfg);
         wr(8'hf3, {4'h0, sz});
         repeat (8)
         begin
            r = $random(seed);
            a = r[4] ? hot[r[3:0]] : {6'h00, r[25:16]};
            e = exio(cfg, sz, 16'h0340, a);
            f = |(e & {2'b11, cs});
            host(XB_IO, r[5], 4'h0, {16'h0000, a}, r[15:8], {e, 2'b00}, f,
               (f && !r[5]) ? (a[7:0] ^ 8'h5a) : 8'h00);
         end
      end
      rst(3'h5);
      wr(8'h30, 8'h01);
      rd(8'hf0, 8'h00);
      rd(8'hf9, 8'h00);
      host(XB_HUB, 1'b0, 4'h0, 32'hffc0_0000, 8'h00, 7'h01, 1'b1, 8'h5a);
      rd(8'hf4, 8'h08);
      rst(3'h0);
      wr(8'h30, 8'h01);
      rd(8'hf4, 8'h00);
      host(XB_MEM, 1'b0, 4'h0, 32'h000f_0000, 8'h00, 7'h00, 1'b0, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
